/* File: common/serial_eeprom_cfg.svh */
// Constants of the three-wire serial memory command interface.
// Assumes one system clock at 10 MHz and a serial clock owned by the master.
`ifndef SERIAL_EEPROM_CFG_SVH
`define SERIAL_EEPROM_CFG_SVH

// Opcodes after the start bit, and the upper address bits of opcode 00
`define OP_READ        2'h2
`define OP_WRITE       2'h1
`define OP_ERASE       2'h3
`define OP_EXT         2'h0
`define SUB_ERASE_ALL  2'h2
`define SUB_LOCK       2'h0
`define SUB_UNLOCK     2'h3
`define SUB_WRITE_ALL  2'h1

// Bits after the start bit: opcode plus address, then data
`define HDR_BYTE       11
`define HDR_WORD       10
`define DATA_BYTE      8
`define DATA_WORD      16
`define MEM_BYTES      512
`define ERASED_BYTE    8'hff

// Programming times as printed, and their cycle counts at the system clock
`define CLOCK_KHZ      10000
`define PROG_WRITE_MS  2
`define PROG_ERASE_ALL_CMD_MS   6
`define PROG_WRITE_ALL_CMD_MS   15
`define TIMER_W        18
`define PROG_WRITE_CYCLES (`PROG_WRITE_MS * `CLOCK_KHZ)
`define PROG_ERASE_ALL_CMD_CYCLES  (`PROG_ERASE_ALL_CMD_MS * `CLOCK_KHZ)
`define PROG_WRITE_ALL_CMD_CYCLES  (`PROG_WRITE_ALL_CMD_MS * `CLOCK_KHZ)

`endif

/* File: common/serial_eeprom_pkg.sv */
// Types shared by the serial memory command interface.
// Assumes the constants header is compiled alongside.
package serial_eeprom_pkg;

    // Commands that reach the programming engine
    typedef enum logic [2:0] {
        op_erase,
        op_erase_all,
        op_write,
        op_write_all,
        op_lock,
        op_unlock
    } op_type;

    // Command handed from the serial clock domain to the system domain
    typedef struct packed {
        op_type      op;
        logic [8:0]  addr;
        logic [15:0] data;
    } cmd_type;

    // Position in the serial sequence
    typedef enum logic [1:0] {
        ls_idle,
        ls_collect,
        ls_read,
        ls_done
    } link_state_type;

endpackage

/* File: core/prog_cycle_timer.sv */
// Self-timed programming cycle counter.
// Assumes a load count of at least one and a start pulse only while idle.
`timescale 1ns/100ps
`include "serial_eeprom_cfg.svh"

module prog_cycle_timer
(
    input  wire logic                clock,
    input  wire logic                rst_b,
    input  wire logic                start,
    input  wire logic [`TIMER_W-1:0] load_count,
    output logic                     busy,
    output logic                     done
);

    logic [`TIMER_W-1:0] remaining;

    ////////////////////////////////////////////////////////////////////////
    // Count down on the system clock; no serial edge is needed
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            remaining <= '0;
        else if (start)
            remaining <= load_count;
        else if (remaining != '0)
            remaining <= remaining - `TIMER_W'(1);
    end

    // Done pulses in the cycle after the last counted cycle
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            done <= 1'b0;
        else
            done <= (remaining == `TIMER_W'(1));
    end

    assign busy = (remaining != '0);

endmodule

/* File: core/serial_eeprom_command_interface.sv */
// Command decoder, read shifter and programming engine of a small serial
// electrically erasable memory. Assumes the master owns serial_clk and
// select; the memory array is written on clock and read on serial_clk.
`timescale 1ns/100ps
`include "serial_eeprom_cfg.svh"

module serial_eeprom_command_interface
#(
    parameter bit          word_org         = 1'b0,
    parameter int unsigned write_cycles     = `PROG_WRITE_CYCLES,
    parameter int unsigned erase_all_cycles = `PROG_ERASE_ALL_CMD_CYCLES,
    parameter int unsigned write_all_cycles = `PROG_WRITE_ALL_CMD_CYCLES
)
(
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic serial_clk,
    input  wire logic select,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_oe
);

    localparam int HDR   = word_org ? `HDR_WORD : `HDR_BYTE;
    localparam int DLEN  = word_org ? `DATA_WORD : `DATA_BYTE;
    localparam int TOT   = HDR + DLEN;
    localparam int ABITS = HDR - 2;

    // Dual-port array: written on clock, read on serial_clk
    logic [7:0] mem [0:`MEM_BYTES-1];

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers

    // Map opcode and upper address bits to an engine command
    function automatic serial_eeprom_pkg::op_type cmd_op(input logic [1:0] opc,
                                                         input logic [1:0] sub);
        serial_eeprom_pkg::op_type res;
        res = serial_eeprom_pkg::op_lock;
        unique case (opc)
            `OP_ERASE: res = serial_eeprom_pkg::op_erase;
            `OP_WRITE: res = serial_eeprom_pkg::op_write;
            `OP_READ:  res = serial_eeprom_pkg::op_lock;
            `OP_EXT:
                unique case (sub)
                    `SUB_ERASE_ALL: res = serial_eeprom_pkg::op_erase_all;
                    `SUB_WRITE_ALL: res = serial_eeprom_pkg::op_write_all;
                    `SUB_UNLOCK:    res = serial_eeprom_pkg::op_unlock;
                    `SUB_LOCK:      res = serial_eeprom_pkg::op_lock;
                endcase
        endcase
        return res;
    endfunction

    // Read one location, left aligned
    function automatic logic [15:0] fetch(input logic [8:0] a);
        logic [15:0] w;
        if (word_org)
            w = {mem[{a[7:0], 1'b0}], mem[{a[7:0], 1'b1}]};
        else
            w = {mem[a], 8'h00};
        return w;
    endfunction

    // Next location; word mode wraps within 256 words
    function automatic logic [8:0] addr_inc(input logic [8:0] a);
        logic [8:0] n;
        n = a + 9'h001;
        if (word_org)
            n[8] = 1'b0;
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial clock domain: reset bring-in and acknowledge synchroniser

    logic link_rst_s1;
    logic link_rst_b;
    logic ack_s1;
    logic ack_s2;
    logic ack_tog;
    logic req_tog;
    logic link_busy;

    // Reset of the handshake needs serial clock edges during rst_b
    always_ff @(posedge serial_clk)
    begin
        link_rst_s1 <= rst_b;
        link_rst_b  <= link_rst_s1;
    end

    // Acknowledge toggle from the system domain
    always_ff @(posedge serial_clk)
    begin
        if (!link_rst_b)
        begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end
        else
        begin
            ack_s1 <= ack_tog;
            ack_s2 <= ack_s1;
        end
    end

    assign link_busy = req_tog ^ ack_s2;

    ////////////////////////////////////////////////////////////////////////
    // Serial sequence: state and read shifter held in reset while select is low

    serial_eeprom_pkg::link_state_type state;
    logic [4:0]                        bit_cnt;
    logic [25:0]                       shreg;
    logic [25:0]                       next_sh;
    logic [1:0]                        opc_q;
    logic [8:0]                        addr_q;
    logic [8:0]                        addr_now;
    logic [1:0]                        opc_now;
    logic [8:0]                        rd_addr;
    logic [15:0]                       out_sh;
    logic [4:0]                        out_cnt;
    logic                              link_bit;
    logic                              link_oe;
    logic                              issue;
    serial_eeprom_pkg::cmd_type        issue_cmd;
    serial_eeprom_pkg::cmd_type        cmd_hold;

    assign next_sh  = {shreg[24:0], serial_in};
    assign opc_now  = next_sh[HDR-1:HDR-2];
    assign addr_now = 9'(next_sh[ABITS-1:0]);

    // Decide whether this edge completes an executable command
    always_comb
    begin
        issue     = 1'b0;
        issue_cmd = '0;
        if (state == serial_eeprom_pkg::ls_collect)
        begin
            if (bit_cnt == 5'(HDR - 1) && opc_now != `OP_READ && opc_now != `OP_WRITE
                && !(opc_now == `OP_EXT && addr_now[ABITS-1 -: 2] == `SUB_WRITE_ALL))
            begin
                issue          = !link_busy;
                issue_cmd.op   = cmd_op(opc_now, addr_now[ABITS-1 -: 2]);
                issue_cmd.addr = addr_now;
            end
            else if (bit_cnt == 5'(TOT - 1))
            begin
                issue          = !link_busy;
                issue_cmd.op   = cmd_op(opc_q, addr_q[ABITS-1 -: 2]);
                issue_cmd.addr = addr_q;
                issue_cmd.data = 16'(next_sh[DLEN-1:0]);
            end
        end
    end

    // Sequence position; select low is an asynchronous constant reset
    always_ff @(posedge serial_clk or negedge select)
    begin
        if (!select)
        begin
            state   <= serial_eeprom_pkg::ls_idle;
            bit_cnt <= 5'h00;
            shreg   <= 26'h000_0000;
            opc_q   <= 2'h0;
            addr_q  <= 9'h000;
        end
        else
        begin
            unique case (state)
                serial_eeprom_pkg::ls_idle:
                    if (serial_in)
                        state <= serial_eeprom_pkg::ls_collect;
                serial_eeprom_pkg::ls_collect:
                begin
                    shreg   <= next_sh;
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'(HDR - 1))
                    begin
                        opc_q  <= opc_now;
                        addr_q <= addr_now;
                        if (opc_now == `OP_READ)
                            state <= link_busy ? serial_eeprom_pkg::ls_done
                                               : serial_eeprom_pkg::ls_read;
                        else if (issue)
                            state <= serial_eeprom_pkg::ls_done;
                        else if (opc_now == `OP_EXT
                                 && addr_now[ABITS-1 -: 2] != `SUB_WRITE_ALL)
                            state <= serial_eeprom_pkg::ls_done;
                        else if (link_busy && opc_now != `OP_WRITE
                                 && opc_now != `OP_EXT)
                            state <= serial_eeprom_pkg::ls_done;
                    end
                    else if (bit_cnt == 5'(TOT - 1))
                        state <= serial_eeprom_pkg::ls_done;
                end
                serial_eeprom_pkg::ls_read:
                    state <= serial_eeprom_pkg::ls_read;
                serial_eeprom_pkg::ls_done:
                    state <= serial_eeprom_pkg::ls_done;
            endcase
        end
    end

    // Read shifter; its drive of the pin ends the moment select falls
    always_ff @(posedge serial_clk or negedge select)
    begin
        if (!select)
        begin
            link_oe  <= 1'b0;
            link_bit <= 1'b0;
            out_sh   <= 16'h0000;
            out_cnt  <= 5'h00;
            rd_addr  <= 9'h000;
        end
        else if (state == serial_eeprom_pkg::ls_collect && bit_cnt == 5'(HDR - 1)
                 && opc_now == `OP_READ && !link_busy)
        begin
            link_oe  <= 1'b1;
            link_bit <= 1'b0;
            out_cnt  <= 5'h00;
            rd_addr  <= addr_now;
        end
        else if (state == serial_eeprom_pkg::ls_read)
        begin
            if (out_cnt == 5'h00)
            begin
                link_bit <= fetch(rd_addr)[15];
                out_sh   <= {fetch(rd_addr)[14:0], 1'b0};
                out_cnt  <= 5'(DLEN - 1);
                rd_addr  <= addr_inc(rd_addr);
            end
            else
            begin
                link_bit <= out_sh[15];
                out_sh   <= {out_sh[14:0], 1'b0};
                out_cnt  <= out_cnt - 5'h01;
            end
        end
    end

    // Request toggle and held command survive select going low
    always_ff @(posedge serial_clk)
    begin
        if (!link_rst_b)
        begin
            req_tog  <= 1'b0;
            cmd_hold <= '0;
        end
        else if (issue)
        begin
            req_tog  <= ~req_tog;
            cmd_hold <= issue_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System clock domain: command intake and programming engine

    logic                         req_s1;
    logic                         req_s2;
    logic                         req_seen;
    logic                         new_req;
    logic                         unlocked;
    logic                         prog_busy;
    logic                         sweeping;
    logic [8:0]                   sweep_idx;
    serial_eeprom_pkg::cmd_type   cur;
    logic                         timer_start;
    logic [`TIMER_W-1:0]          timer_load;
    logic                         timer_busy;
    logic                         accept;

    // Request toggle synchroniser
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end
        else
        begin
            req_s1 <= req_tog;
            req_s2 <= req_s1;
        end
    end

    assign new_req     = (req_s2 != req_seen) && !prog_busy;
    assign accept      = new_req && unlocked && cmd_hold.op != serial_eeprom_pkg::op_lock
                         && cmd_hold.op != serial_eeprom_pkg::op_unlock;
    assign timer_start = accept;

    // Cycle length per command kind
    always_comb
    begin
        unique case (cmd_hold.op)
            serial_eeprom_pkg::op_erase_all: timer_load = `TIMER_W'(erase_all_cycles);
            serial_eeprom_pkg::op_write_all: timer_load = `TIMER_W'(write_all_cycles);
            default:                         timer_load = `TIMER_W'(write_cycles);
        endcase
    end

    // Intake, lock state and acknowledge; select plays no part here
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            req_seen  <= 1'b0;
            unlocked  <= 1'b0;
            prog_busy <= 1'b0;
            ack_tog   <= 1'b0;
            cur       <= '0;
        end
        else if (new_req)
        begin
            req_seen <= req_s2;
            cur      <= cmd_hold;
            if (cmd_hold.op == serial_eeprom_pkg::op_unlock)
                unlocked <= 1'b1;
            else if (cmd_hold.op == serial_eeprom_pkg::op_lock)
                unlocked <= 1'b0;
            if (accept)
                prog_busy <= 1'b1;
            else
                ack_tog <= ~ack_tog;
        end
        else if (prog_busy && !timer_busy && !timer_start && !sweeping)
        begin
            prog_busy <= 1'b0;
            ack_tog   <= ~ack_tog;
        end
    end

    // Whole-array sweep, one byte per clock
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sweeping  <= 1'b0;
            sweep_idx <= 9'h000;
        end
        else if (accept && (cmd_hold.op == serial_eeprom_pkg::op_erase_all
                            || cmd_hold.op == serial_eeprom_pkg::op_write_all))
        begin
            sweeping  <= 1'b1;
            sweep_idx <= 9'h000;
        end
        else if (sweeping)
        begin
            sweep_idx <= sweep_idx + 9'h001;
            if (sweep_idx == 9'(`MEM_BYTES - 1))
                sweeping <= 1'b0;
        end
    end

    // Array writes; write-all lands the data straight over the old contents, with no erase first
    always_ff @(posedge clock)
    begin
        if (accept && cmd_hold.op == serial_eeprom_pkg::op_erase)
        begin
            if (word_org)
            begin
                mem[{cmd_hold.addr[7:0], 1'b0}] <= `ERASED_BYTE;
                mem[{cmd_hold.addr[7:0], 1'b1}] <= `ERASED_BYTE;
            end
            else
                mem[cmd_hold.addr] <= `ERASED_BYTE;
        end
        else if (accept && cmd_hold.op == serial_eeprom_pkg::op_write)
        begin
            if (word_org)
            begin
                mem[{cmd_hold.addr[7:0], 1'b0}] <= cmd_hold.data[15:8];
                mem[{cmd_hold.addr[7:0], 1'b1}] <= cmd_hold.data[7:0];
            end
            else
                mem[cmd_hold.addr] <= cmd_hold.data[7:0];
        end
        else if (sweeping)
        begin
            if (cur.op == serial_eeprom_pkg::op_erase_all)
                mem[sweep_idx] <= `ERASED_BYTE;
            else if (word_org && !sweep_idx[0])
                mem[sweep_idx] <= cur.data[15:8];
            else
                mem[sweep_idx] <= cur.data[7:0];
        end
    end

    // Cycle timer; its end pulse goes unused, the busy level ends the cycle
    prog_cycle_timer u_timer
    (
        .clock      (clock),
        .rst_b      (rst_b),
        .start      (timer_start),
        .load_count (timer_load),
        .busy       (timer_busy),
        .done       ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Ready/busy status on reselect

    logic sel_s1;
    logic sel_s2;
    logic sel_q;
    logic armed;
    logic show;
    logic status_bit;

    // Select synchroniser and edge memory
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            sel_q  <= 1'b0;
        end
        else
        begin
            sel_s1 <= select;
            sel_s2 <= sel_s1;
            sel_q  <= sel_s2;
        end
    end

    // Armed by a programming start, shown only on a fresh select rise
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            armed <= 1'b0;
            show  <= 1'b0;
        end
        else if (accept)
            armed <= 1'b1;
        else if (sel_s2 && !sel_q && armed)
            show <= 1'b1;
        else if (!sel_s2 && sel_q && show)
        begin
            show  <= 1'b0;
            armed <= prog_busy;
        end
    end

    // Status level registered; low while busy
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            status_bit <= 1'b0;
        else
            status_bit <= !prog_busy;
    end

    // Read data has the pin first; status only otherwise
    assign serial_out    = link_oe ? link_bit : status_bit;
    assign serial_out_oe = link_oe | show;

endmodule

/* File: tb/serial_eeprom_props.sv */
// Port assertions for the serial memory command interface.
// Assumes byte organization and a master that idles its clock between frames.
`timescale 1ns/100ps

module serial_eeprom_props
#(
    parameter int unsigned write_all_cycles = 800
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic serial_clk,
    input wire logic select,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    int unsigned busy_run;

    // Length of the busy status run now shown; a deselect breaks it early
    always_ff @(posedge clock)
    begin
        if (!rst_b || !(select && serial_out_oe && !serial_out))
            busy_run <= 0;
        else
            busy_run <= busy_run + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_oe_release;
        @(posedge clock) disable iff (!rst_b) $fell(select) |-> ##[1:6] !serial_out_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("output still driven after deselect");
    property p_status_hidden;
        @(posedge clock) disable iff (!rst_b) !select [*8] |-> !serial_out_oe;
    endproperty
    a_status_hidden: assert property (p_status_hidden)
        else $error("status shown while deselected");
    property p_idle_after_reset;
        @(posedge clock) disable iff (!rst_b) $rose(rst_b) |-> !serial_out_oe;
    endproperty
    a_idle_after_reset: assert property (p_idle_after_reset)
        else $error("output driven right after reset");
    property p_oe_needs_select;
        @(posedge clock) disable iff (!rst_b) $rose(serial_out_oe) |-> select;
    endproperty
    a_oe_needs_select: assert property (p_oe_needs_select)
        else $error("output enabled without select");
    property p_busy_bounded;
        @(posedge clock) disable iff (!rst_b) busy_run <= write_all_cycles + 20;
    endproperty
    a_busy_bounded: assert property (p_busy_bounded)
        else $error("busy status never ends");
    property p_deselected_quiet;
        @(posedge serial_clk) disable iff (!rst_b) !select |-> !serial_out_oe;
    endproperty
    a_deselected_quiet: assert property (p_deselected_quiet)
        else $error("output driven while deselected");
    property p_read_dummy;
        @(posedge serial_clk) disable iff (!rst_b) $rose(serial_out_oe) |-> !serial_out;
    endproperty
    a_read_dummy: assert property (p_read_dummy)
        else $error("read data not led by a zero");
    property p_read_hold;
        @(posedge serial_clk) disable iff (!rst_b) $rose(serial_out_oe) |=> serial_out_oe [*8];
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read output dropped mid word");
endmodule

bind serial_eeprom_command_interface serial_eeprom_props
    #(.write_all_cycles(write_all_cycles)) u_props (.clock(clock), .rst_b(rst_b),
    .serial_clk(serial_clk), .select(select), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

/* File: tb/serial_master_model.sv */
// Master model driving select, serial clock and serial input.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/100ps

module serial_master_model
(
    output logic      serial_clk,
    output logic      select,
    output logic      serial_in,
    input  wire logic serial_out
);
    // Clock and select stand low outside frames, save the clock during idle
    initial
    begin
        serial_clk = 1'b0;
        select     = 1'b0;
        serial_in  = 1'b0;
    end

    // One period at 15 ns; input moves after the falling edge
    task automatic pulse(input logic b, inout logic [31:0] cap);
        serial_in = b;
        #7.5 serial_clk = 1'b1;
        #3 cap = {cap[30:0], serial_out};
        #4.5 serial_clk = 1'b0;
    endtask

    // Zeros, then n instruction bits, then extra ones; low time after it
    task automatic frame(input logic [31:0] bits, input int n, input int pre,
        input int extra, output logic [31:0] cap);
        cap = 32'h0000_0000;
        select = 1'b1;
        repeat (pre) pulse(1'b0, cap);
        for (int i = n - 1; i >= 0; i--)
        begin
            if (pre > 0 && i == n / 2) #300; // Clock halted low mid-frame
            pulse(bits[i], cap);
        end
        repeat (extra) pulse(1'b1, cap);
        select = 1'b0;
        serial_in = ~serial_in; // Released line must not look held
        #400;
    endtask

    task automatic sel(input logic v);
        select = v;
    endtask

    // Eight clock pulses with select low and input high
    task automatic idle;
        serial_in = 1'b1;
        repeat (8)
        begin
            #7.5 serial_clk = 1'b1;
            #7.5 serial_clk = 1'b0;
        end
        serial_in = 1'b0;
    endtask
endmodule

/* File: tb/tb_serial_eeprom_command_interface.sv */
// Self-checking bench for the serial memory command interface.
// Assumes byte organization and shortened programming times.
`timescale 1ns/100ps

module tb_serial_eeprom_command_interface;
    logic        clock;
    logic        rst_b;
    logic        serial_clk;
    logic        select;
    logic        serial_in;
    logic        serial_out;
    logic        serial_out_oe;
    logic        line_seen;
    logic [31:0] cap;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    serial_eeprom_command_interface #(.write_cycles(600), .erase_all_cycles(700),
        .write_all_cycles(800)) uut (.clock(clock), .rst_b(rst_b), .serial_clk(serial_clk),
        .select(select), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe));
    // Line as the master sees it: pulled up whenever the device lets go
    assign line_seen = serial_out_oe ? serial_out : 1'b1;
    serial_master_model master (.serial_clk(serial_clk), .select(select),
        .serial_in(serial_in), .serial_out(line_seen));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Sends the first n bits of start, opcode, address and data
    task automatic send(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
        input int n, input int pre, input int extra);
        master.frame({12'h000, 1'b1, op, a, d} >> (20 - n), n, pre, extra, cap);
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
        send(2'h2, a, 8'h00, 12, 0, 16);
        chk(cap[16:0], {1'b0, e0, e1});
    endtask

    // Select alone; status shown, busy first when expected, then ready, or not at all
    task automatic status(input logic shown, input logic busy);
        master.sel(1'b1);
        repeat (6) @(posedge clock);
        #1;
        chk(serial_out_oe, shown);
        if (shown)
        begin
            if (busy) chk(serial_out, 1'b0);
            for (int i = 0; i < 1000 && serial_out !== 1'b1; i++) @(posedge clock);
            #1;
            chk(serial_out, 1'b1);
        end
        master.sel(1'b0);
        #600;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Locked write refused, then unlock and clear the whole array
    task automatic t_erase_all;
        send(2'h1, 9'h0a5, 8'h3c, 20, 0, 0);
        status(1'b0, 1'b0);
        send(2'h0, 9'h180, 8'h00, 12, 0, 0);
        send(2'h0, 9'h100, 8'h00, 12, 0, 0);
        status(1'b1, 1'b1);
        rd(9'h0a5, 8'hff, 8'hff);
        $display("erase all done");
    endtask

    // Write with idle clocks, a halted clock and trailing bits
    task automatic t_write;
        send(2'h1, 9'h0a5, 8'h3c, 20, 5, 4);
        repeat (800) @(posedge clock); // Select low through the cycle
        status(1'b1, 1'b0);
        rd(9'h0a5, 8'h3c, 8'hff);
        $display("write done");
    endtask

    // Lock refuses the next write but not reads
    task automatic t_lock;
        send(2'h0, 9'h000, 8'h00, 12, 0, 0);
        send(2'h1, 9'h0a5, 8'h55, 20, 0, 0);
        status(1'b0, 1'b0);
        rd(9'h0a5, 8'h3c, 8'hff);
        $display("lock done");
    endtask

    // A cut frame does nothing; a full erase clears one location
    task automatic t_erase;
        send(2'h0, 9'h180, 8'h00, 12, 0, 0);
        send(2'h3, 9'h0a5, 8'h00, 8, 0, 0); // Cut short
        rd(9'h0a5, 8'h3c, 8'hff);
        send(2'h3, 9'h0a5, 8'h00, 12, 0, 0);
        status(1'b1, 1'b1);
        rd(9'h0a5, 8'hff, 8'hff);
        $display("erase done");
    endtask

    // Fill the array, then read across the wrap
    task automatic t_write_all;
        send(2'h0, 9'h080, 8'h5a, 20, 0, 0);
        status(1'b1, 1'b1);
        master.idle(); // Deselected clocks with input high
        rd(9'h1ff, 8'h5a, 8'h5a);
        $display("write all done");
    endtask

    // Cuts a hang short
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        rst_b = 1'b0;
        master.idle(); // Serial side flops need edges inside reset
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        t_erase_all();
        t_write();
        t_lock();
        t_erase();
        t_write_all();
        summarize();
    end
endmodule
